// ---- core/sram_cycle_pkg.sv ----
// constants and types for the sram cycle decoder
package sram_cycle_pkg;
	localparam int ADDR_W = 19;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int BURST_W = 2;
	localparam int SLEEP_ENTER_CYCLES = 2;
	localparam int SLEEP_EXIT_CYCLES = 2;
	localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
	localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
	typedef enum logic [1:0] {
		CYC_DESELECT,
		CYC_READ,
		CYC_WRITE
	} cycle_t;
endpackage

// ---- core/sram_array.sv ----
// byte-lane writable storage array with registered read data
`timescale 1ns/10ps
module sram_array
	import sram_cycle_pkg::*;
(
	input wire logic sys_clk,
	input wire logic wrEn,
	input wire logic [LANES-1:0] laneEn,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic rdEn,
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [DATA_W-1:0] rdData
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < LANES; i++) begin
			if (wrEn && laneEn[i]) begin
				mem[wrAddr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
			end
		end
		if (rdEn) begin
			rdData <= mem[rdAddr];
		end
	end
endmodule

// ---- core/sram_cycle_decode.sv ----
// synchronous no-turnaround sram command decode and cycle control
// Function
// - all state changes on rising clock edge
// - select plus load plus read starts read
// - advance continues read at next burst address
// - read with output disable is dummy read
// - select, load, write, lane enable starts write
// - advance with lane enable continues write
// - low lane enables write bytes; none aborts
// - read select ignores lane write enables
// - sleep forces data pins undriven
// - deselect and write keep pins undriven
// - clock gating high holds access state; sleep logic still runs
// - write data captured one cycle later
// - two-bit wrapping burst, linear or interleaved
// - sleep entry and exit take two cycles
`timescale 1ns/10ps
module no_turnaround_sram_cycle_decode
	import sram_cycle_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic firstSelectLow,
	input wire logic secondSelectHigh,
	input wire logic thirdSelectLow,
	input wire logic advanceLoad,
	input wire logic readWriteSel,
	input wire logic [LANES-1:0] byteLaneWriteEnable,
	input wire logic clockGate,
	input wire logic [ADDR_W-1:0] extAddr,
	input wire logic outputDisable,
	input wire logic sleepRequest,
	input wire logic burstOrderSelect,
	input wire logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0] dataOut,
	output logic dataOe,
	output logic sleeping,
	output logic [ADDR_W-1:0] curAddr,
	output logic cycleActive
);
	cycle_t cyc_q, cyc_d;
	logic [ADDR_W-1:0] base_q, base_d;
	logic [BURST_W-1:0] cnt_q, cnt_d;
	logic burstOrder_q;
	logic sleepMeta_q, sleepSync_q;
	logic burstMeta_q, burstSync_q;
	logic odMeta_q, odSync_q;
	logic [1:0] sleepCnt_q;
	logic sleepState_q;
	logic wrPend_q;
	logic [LANES-1:0] wrLanes_q;
	logic [ADDR_W-1:0] wrAddr_q;
	logic readDrive_q;

	// decode of the synchronous command on this edge
	wire selected = !firstSelectLow && secondSelectHigh && !thirdSelectLow;
	wire edgeLive = !clockGate && !sleepState_q;
	wire loadEdge = edgeLive && !advanceLoad;
	wire advEdge = edgeLive && advanceLoad;
	wire anyLane = |(~byteLaneWriteEnable);
	wire beginRead = loadEdge && selected && readWriteSel;
	wire beginWrite = loadEdge && selected && !readWriteSel;
	wire deselEdge = loadEdge && !selected;
	wire contRead = advEdge && cyc_q == CYC_READ;
	wire contWrite = advEdge && cyc_q == CYC_WRITE;
	wire [BURST_W-1:0] cntNext = cnt_q + 2'h1;
	// interleaved order xors the step into the start bits
	wire [BURST_W-1:0] nextLow = burstOrder_q ?
		(base_q[BURST_W-1:0] ^ cntNext) :
		(base_q[BURST_W-1:0] + cntNext);
	wire [ADDR_W-1:0] nextAddr = {base_q[ADDR_W-1:BURST_W], nextLow};
	wire [ADDR_W-1:0] accAddr = (beginRead || beginWrite) ? extAddr
		: nextAddr;
	// all-high lanes abort: address still moves, nothing stored
	wire doWrite = (beginWrite || contWrite) && anyLane;
	wire doRead = beginRead || contRead;
	wire accessEdge = beginRead || beginWrite || contRead || contWrite;

	always_comb begin
		cyc_d = cyc_q;
		base_d = base_q;
		cnt_d = cnt_q;
		if (beginRead || beginWrite) begin
			cyc_d = beginRead ? CYC_READ : CYC_WRITE;
			base_d = extAddr;
			cnt_d = BURST_RST;
		end else if (deselEdge) begin
			cyc_d = CYC_DESELECT;
		end else if (contRead || contWrite) begin
			cnt_d = cntNext;
		end
		// advance while deselected continues deselect, relying on the
		// controller having issued a deselect first
		if (advEdge && cyc_q == CYC_DESELECT) begin
			cyc_d = CYC_DESELECT;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cyc_q <= CYC_DESELECT;
			base_q <= ADDR_RST;
			cnt_q <= BURST_RST;
		end else begin
			cyc_q <= cyc_d;
			base_q <= base_d;
			cnt_q <= cnt_d;
		end
	end

	// strap pin is asynchronous too, so it gets its own two flops
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			burstMeta_q <= 1'b0;
			burstSync_q <= 1'b0;
		end else begin
			burstMeta_q <= burstOrderSelect;
			burstSync_q <= burstMeta_q;
		end
	end

	// order latched only on live deselected edges, never mid-burst
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			burstOrder_q <= 1'b0;
		end else if (edgeLive && cyc_q == CYC_DESELECT) begin
			burstOrder_q <= burstSync_q;
		end
	end

	// asynchronous pins pass two flops
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sleepMeta_q <= 1'b0;
			sleepSync_q <= 1'b0;
			odMeta_q <= 1'b1;
			odSync_q <= 1'b1;
		end else begin
			sleepMeta_q <= sleepRequest;
			sleepSync_q <= sleepMeta_q;
			odMeta_q <= outputDisable;
			odSync_q <= odMeta_q;
		end
	end

	// sleep state flips after the request holds for the set count
	wire sleepDiff = sleepSync_q != sleepState_q;
	wire [1:0] sleepLimit = sleepState_q ? 2'(SLEEP_EXIT_CYCLES)
		: 2'(SLEEP_ENTER_CYCLES);
	// output copy flips with the state so gated edges line up
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sleepCnt_q <= SLEEP_CNT_RST;
			sleepState_q <= 1'b0;
			sleeping <= 1'b0;
		end else if (!sleepDiff) begin
			sleepCnt_q <= SLEEP_CNT_RST;
		end else if (sleepCnt_q + 2'h1 >= sleepLimit) begin
			sleepCnt_q <= SLEEP_CNT_RST;
			sleepState_q <= sleepSync_q;
			sleeping <= sleepSync_q;
		end else begin
			sleepCnt_q <= sleepCnt_q + 2'h1;
		end
	end

	// late write: lanes and address held one cycle for the data
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wrPend_q <= 1'b0;
			wrLanes_q <= '0;
			wrAddr_q <= ADDR_RST;
		end else if (edgeLive) begin
			wrPend_q <= doWrite;
			wrLanes_q <= ~byteLaneWriteEnable;
			wrAddr_q <= accAddr;
		end
	end

	wire arrWrite = wrPend_q && edgeLive;

	sram_array u_array (
		.sys_clk(sys_clk),
		.wrEn(arrWrite),
		.laneEn(wrLanes_q),
		.wrAddr(wrAddr_q),
		.wrData(dataIn),
		.rdEn(doRead),
		.rdAddr(accAddr),
		.rdData(dataOut)
	);

	// pins driven only for real reads, never asleep or writing
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			readDrive_q <= 1'b0;
			dataOe <= 1'b0;
		end else begin
			if (edgeLive) begin
				readDrive_q <= doRead;
			end
			dataOe <= (edgeLive ? doRead : readDrive_q) && !odSync_q
				&& !sleepSync_q && !sleepState_q;
		end
	end

	// the address only moves on an access, so gated edges hold it
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			curAddr <= ADDR_RST;
			cycleActive <= 1'b0;
		end else begin
			if (accessEdge) begin
				curAddr <= accAddr;
			end
			// from the next state, so it agrees with curAddr
			cycleActive <= cyc_d != CYC_DESELECT;
		end
	end
endmodule

// ---- tb/sram_cycle_decode_sva.sv ----
// port assertions for the sram cycle decoder
`timescale 1ns/10ps
module sram_cycle_decode_sva
	import sram_cycle_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic firstSelectLow,
	input wire logic secondSelectHigh,
	input wire logic thirdSelectLow,
	input wire logic advanceLoad,
	input wire logic readWriteSel,
	input wire logic [LANES-1:0] byteLaneWriteEnable,
	input wire logic clockGate,
	input wire logic [ADDR_W-1:0] extAddr,
	input wire logic dataOe,
	input wire logic sleeping,
	input wire logic [ADDR_W-1:0] curAddr,
	input wire logic cycleActive
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	wire live = !clockGate && !sleeping;
	wire sel = !firstSelectLow && secondSelectHigh && !thirdSelectLow;
	wire rdLd = live && sel && !advanceLoad && readWriteSel;
	wire wrLd = live && sel && !advanceLoad && !readWriteSel
		&& !(&byteLaneWriteEnable);
	a_gate_holds_addr: assert property (
		clockGate |=> $stable(curAddr)) else $error("gated addr moved");
	a_gate_holds_state: assert property (
		clockGate |=> $stable(cycleActive)) else $error("gated state moved");
	a_read_load_addr: assert property (
		rdLd |=> curAddr == $past(extAddr)) else $error("read addr wrong");
	a_write_load_addr: assert property (
		wrLd |=> curAddr == $past(extAddr)) else $error("write addr wrong");
	a_load_sets_active: assert property (
		rdLd || wrLd |=> cycleActive) else $error("no burst state");
	a_burst_step: assert property (
		live && advanceLoad && cycleActive |=>
		(curAddr >> 2) == ($past(curAddr) >> 2)
		&& curAddr[1:0] != $past(curAddr[1:0])) else $error("bad step");
	a_idle_no_drive: assert property (
		live && !advanceLoad && !(sel && readWriteSel) |=> !dataOe)
		else $error("pins driven");
	a_sleep_no_drive: assert property (
		sleeping |-> !dataOe) else $error("driven in sleep");
endmodule
bind no_turnaround_sram_cycle_decode sram_cycle_decode_sva chk (
	.sys_clk(sys_clk),
	.srst(srst),
	.firstSelectLow(firstSelectLow),
	.secondSelectHigh(secondSelectHigh),
	.thirdSelectLow(thirdSelectLow),
	.advanceLoad(advanceLoad),
	.readWriteSel(readWriteSel),
	.byteLaneWriteEnable(byteLaneWriteEnable),
	.clockGate(clockGate),
	.extAddr(extAddr),
	.dataOe(dataOe),
	.sleeping(sleeping),
	.curAddr(curAddr),
	.cycleActive(cycleActive)
);

// ---- tb/sram_ctrl_model.sv ----
// memory controller model driving the synchronous bus
`timescale 1ns/10ps
module sram_ctrl_model
	import sram_cycle_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [1:0] op,
	input wire logic [LANES-1:0] lanes,
	input wire logic [DATA_W-1:0] wdata,
	output logic firstSelectLow,
	output logic advanceLoad,
	output logic readWriteSel,
	output logic [LANES-1:0] byteLaneWriteEnable,
	output logic [DATA_W-1:0] dataIn
);
	// op: 0 deselect, 1 load read, 2 load write, 3 advance
	assign firstSelectLow = (op == 2'h0);
	assign advanceLoad = (op == 2'h3);
	assign readWriteSel = (op == 2'h1);
	assign byteLaneWriteEnable = lanes;
	logic [DATA_W-1:0] busData_q = '0;
	assign dataIn = busData_q;
	// idle bus flips so stale data never looks valid
	always @(negedge sys_clk) begin
		busData_q <= (op[1] && lanes != 4'hF) ? wdata
			: ~busData_q;
	end
endmodule

// ---- tb/no_turnaround_sram_cycle_decode_tb_top.sv ----
// self-checking bench for the sram cycle decoder
`timescale 1ns/10ps
module no_turnaround_sram_cycle_decode_tb_top;
	import sram_cycle_pkg::*;
	localparam logic [DATA_W-1:0] D0 = 36'h123456789, D1 = 36'hABCDEF012;
	localparam logic [DATA_W-1:0] D2 = 36'h0FEDCBA98;
	logic sys_clk = 1'h0, srst = 1'h1, clockGate = 1'h0, sleepRequest = 1'h0;
	logic secondSelectHigh = 1'h1, thirdSelectLow = 1'h0;
	logic outputDisable = 1'h0, burstOrderSelect = 1'h0;
	logic [1:0] op = 2'h0;
	logic [LANES-1:0] lanes = 4'hF, byteLaneWriteEnable;
	logic [ADDR_W-1:0] extAddr = 19'h0, curAddr;
	logic [DATA_W-1:0] wdata = 36'h0, dataIn, dataOut;
	logic firstSelectLow, advanceLoad, readWriteSel;
	logic dataOe, sleeping, cycleActive;
	int bad_count = 0, num_checks = 0;
	always #10 sys_clk = ~sys_clk;
	sram_ctrl_model ctrl (
		.sys_clk(sys_clk),
		.op(op),
		.lanes(lanes),
		.wdata(wdata),
		.firstSelectLow(firstSelectLow),
		.advanceLoad(advanceLoad),
		.readWriteSel(readWriteSel),
		.byteLaneWriteEnable(byteLaneWriteEnable),
		.dataIn(dataIn)
	);
	no_turnaround_sram_cycle_decode uut (
		.sys_clk(sys_clk),
		.srst(srst),
		.firstSelectLow(firstSelectLow),
		.secondSelectHigh(secondSelectHigh),
		.thirdSelectLow(thirdSelectLow),
		.advanceLoad(advanceLoad),
		.readWriteSel(readWriteSel),
		.byteLaneWriteEnable(byteLaneWriteEnable),
		.clockGate(clockGate),
		.extAddr(extAddr),
		.outputDisable(outputDisable),
		.sleepRequest(sleepRequest),
		.burstOrderSelect(burstOrderSelect),
		.dataIn(dataIn),
		.dataOut(dataOut),
		.dataOe(dataOe),
		.sleeping(sleeping),
		.curAddr(curAddr),
		.cycleActive(cycleActive)
	);
	task automatic cmd(input logic [1:0] o, input logic [ADDR_W-1:0] a,
		input logic [LANES-1:0] l, input logic [DATA_W-1:0] d);
		@(negedge sys_clk);
		op <= o;
		extAddr <= a;
		lanes <= l;
		wdata <= d;
	endtask
	task automatic check(input logic [DATA_W-1:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge sys_clk);
		srst <= 1'h0;
		cmd(2'h2, 19'h7, 4'h0, D0);
		cmd(2'h3, 19'h0, 4'h0, D1);
		cmd(2'h0, 19'h0, 4'hF, D0);
		cmd(2'h2, 19'h4, 4'hE, D2);
		cmd(2'h3, 19'h0, 4'hF, D0);
		cmd(2'h0, 19'h0, 4'hF, D0);
		cmd(2'h1, 19'h7, 4'h0, D0);
		cmd(2'h3, 19'h0, 4'hF, D0);
		check(dataOut, D0);
		clockGate <= 1'h1;
		repeat (2) @(negedge sys_clk);
		check(curAddr, 19'h7);
		clockGate <= 1'h0;
		cmd(2'h0, 19'h0, 4'hF, D0);
		check(dataOut, {D1[35:9], D2[8:0]});
		check(curAddr, 19'h4);
		check(dataOe, 1'h1);
		cmd(2'h0, 19'h0, 4'hF, D0);
		check(dataOe, 1'h0);
		check(cycleActive, 1'h0);
		$display("burst test done");
		burstOrderSelect <= 1'h1;
		outputDisable <= 1'h1;
		cmd(2'h3, 19'h0, 4'hF, D0);
		cmd(2'h0, 19'h0, 4'hF, D0);
		cmd(2'h1, 19'h5, 4'hF, D0);
		cmd(2'h3, 19'h0, 4'hF, D0);
		check(dataOe, 1'h0);
		check(cycleActive, 1'h1);
		cmd(2'h3, 19'h0, 4'hF, D0);
		check(curAddr, 19'h4);
		check(dataOut, {D1[35:9], D2[8:0]});
		check(dataOe, 1'h0);
		cmd(2'h0, 19'h0, 4'hF, D0);
		check(curAddr, 19'h7);
		check(dataOut, D0);
		outputDisable <= 1'h0;
		burstOrderSelect <= 1'h0;
		$display("order test done");
		sleepRequest <= 1'h1;
		repeat (8) @(negedge sys_clk);
		check(sleeping, 1'h1);
		sleepRequest <= 1'h0;
		repeat (8) @(negedge sys_clk);
		check(sleeping, 1'h0);
		$display("sleep test done");
		tally_and_finish;
	end
endmodule
